// File: sim/fes_dp_model.sv
module fes_dp_model (
  // Request from the bench
  input wire logic fire_in,
  input wire logic [28:0] rep_in,
  // Report towards the status block
  output logic op_valid_out,
  output logic [28:0] rep_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Between reports the lines carry the inverse, so a stale report never passes for a live one.
  assign op_valid_out = fire_in;
  assign rep_out = fire_in ? rep_in : ~rep_in;
endmodule : fes_dp_model

// File: sim/test_fp_exception_status.sv
module test_fp_exception_status;
  timeunit 1ns;
  timeprecision 1ps;
  import fes_pkg::*;
  // Version code is arbitrary.
  localparam logic [2:0] VER_T = 3'h5;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic fire = 1'b0;
  logic ld32 = 1'b0;
  logic ld64 = 1'b0;
  logic st = 1'b0;
  logic st_err = 1'b0;
  logic [28:0] rep = '0;
  logic [63:0] wd = '0;
  logic op_v;
  logic [28:0] rep_w;
  logic [63:0] img;
  logic ieee_t;
  logic misc_t;
  int errors = 0;
  int checks_done = 0;
  logic [4:0] m_cexc = '0, m_aexc = '0, m_tem = '0;
  logic [2:0] m_ftt = '0;
  logic [1:0] m_rd = '0, m_fcc0 = '0;
  logic [5:0] m_fchi = '0;
  logic e_ieee = 1'b0;
  logic e_misc = 1'b0;

  initial begin
    forever #12.5 clock_in = ~clock_in;
  end

  fes_dp_model u_dp (.fire_in(fire), .rep_in(rep), .op_valid_out(op_v), .rep_out(rep_w));

  fes_core #(.VER_CODE(VER_T)) u_dut (
    .clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_v),
    .op_not_in_hw_in(rep_w[28]), .op_quad_in(rep_w[27]), .op_incomplete_in(rep_w[26]),
    .op_quad_regs_in(rep_w[25:23]), .op_rs1_in(rep_w[22:17]), .op_rs2_in(rep_w[16:11]),
    .op_rd_in(rep_w[10:5]), .exc_in(rep_w[4:0]), .status_load_32_in(ld32),
    .status_load_64_in(ld64), .status_wdata_in(wd), .status_store_in(st),
    .store_err_in(st_err), .float_status_control_out(img),
    .float_ieee_trap_out(ieee_t), .float_misc_trap_out(misc_t));

  function automatic logic [63:0] image();
    return {26'h0, m_fchi, m_rd, 2'h0, m_tem, 3'h0, VER_T, m_ftt, 2'h0, m_fcc0, m_aexc, m_cexc};
  endfunction : image

  function automatic logic [4:0] top_bit(input logic [4:0] v);
    for (int b = EXC_W - 1; b >= 0; b--) begin
      if (v[b]) begin
        return 5'h01 << b;
      end
    end
    return 5'h00;
  endfunction : top_bit

  task automatic conclude();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic model_op(input logic [28:0] r);
    logic [4:0] e;
    logic mis;
    // Overflow, and underflow left untrapped, always bring inexact along.
    e = r[4:0] | ((r[3] | (r[2] & !m_tem[EXC_UF])) ? 5'h01 : 5'h00);
    mis = (r[23] & |r[18:17]) | (r[24] & |r[12:11]) | (r[25] & |r[6:5]);
    e_misc = r[28] | r[27] | mis | r[26];
    e_ieee = !e_misc && ((e & m_tem) != 5'h00);
    if (e_misc) begin
      m_ftt = (r[28] | r[27]) ? FTT_NOT_IN_HW : (mis ? FTT_MISALIGNED : FTT_INCOMPLETE);
    end else if (e_ieee) begin
      m_ftt = FTT_IEEE;
      m_cexc = top_bit(e & m_tem);
    end else begin
      m_ftt = FTT_NONE;
      m_cexc = e;
      m_aexc = m_aexc | e;
    end
  endtask : model_op

  // Kinds: 0 idle, 1 op, 2 load32, 3 load64, 4 store, 5 op with load, 6 load with store.
  task automatic step(input int k, input logic [28:0] r, input logic [63:0] d, input logic err);
    @(posedge clock_in);
    fire <= (k == 1 || k == 5);
    ld32 <= (k == 2 || k == 5 || k == 6);
    ld64 <= (k == 3);
    st <= (k == 4 || k == 6);
    st_err <= err;
    rep <= r;
    wd <= d;
    #1;
    check(img, image());
    check({63'h0, ieee_t}, {63'h0, e_ieee});
    check({63'h0, misc_t}, {63'h0, e_misc});
    e_ieee = 1'b0;
    e_misc = 1'b0;
    if (k == 1 || k == 5) begin
      model_op(r);
    end else if (k == 2 || k == 3 || k == 6) begin
      m_cexc = d[4:0];
      m_aexc = d[9:5];
      m_fcc0 = d[11:10];
      m_tem = d[27:23];
      m_rd = d[31:30];
      m_fchi = (k == 3) ? d[37:32] : m_fchi;
    end else if (k == 4 && !err) begin
      m_ftt = FTT_NONE;
    end
  endtask : step

  initial begin
    repeat (5000) @(posedge clock_in);
    errors++;
    conclude();
  end

  initial begin
    logic [28:0] r;
    logic [63:0] d;
    logic err;
    int k;
    k = $urandom(32'h0A4E);
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    check(img, 64'h0);
    $display("Test reset done");
    for (int i = 0; i < 600; i++) begin
      k = $urandom_range(6, 0);
      r = 29'($urandom);
      r[28:26] = ($urandom_range(3, 0) == 0) ? 3'($urandom) : 3'h0;
      r[25:23] = ($urandom_range(3, 0) == 0) ? 3'($urandom) : 3'h0;
      r[4:0] = r[3] ? (r[4:0] & 5'h09) : (r[2] ? (r[4:0] & 5'h05) : r[4:0]);
      d = {$urandom, $urandom};
      err = 1'($urandom);
      case (i)
        0: k = 3;
        1: {k, r} = {32'h1, 29'h00000008};
        2: {k, r} = {32'h1, 29'h1FFFFFFF};
        3: {k, r} = {32'h1, 3'h1, 3'h7, 18'h3FFFF, 5'h00};
        4: k = 6;
        5: {k, err} = {32'h4, 1'b1};
        6: {k, err} = {32'h4, 1'b0};
        7: {k, d} = {32'h2, 64'h0000000000000000};
        8: {k, r} = {32'h1, 29'h00000008};
        9: {k, d} = {32'h2, 64'h0000000000800000};
        10: {k, r} = {32'h1, 29'h00000005};
        11: {k, d} = {32'h3, 64'h0000000001800000};
        12: {k, r} = {32'h1, 29'h00000003};
        default: ;
      endcase
      if (i == 0) begin
        d = 64'hFFFFFFFFFFFFFFFF;
      end
      step(k, r, d, err);
      if (i == 12) begin
        $display("Test corner cases done");
      end
    end
    step(0, 29'h0, 64'h0, 1'b0);
    $display("Test random traffic done");
    conclude();
  end
endmodule : test_fp_exception_status

// File: verilog/fes_cexc_res.sv
module fes_cexc_res (
  // Exceptions and mask
  input wire logic [fes_pkg::EXC_W-1:0] exc_in,
  input wire logic [fes_pkg::EXC_W-1:0] tem_in,
  // Result
  output logic [fes_pkg::EXC_W-1:0] cexc_out,
  output logic trap_out
);
  import fes_pkg::*;
  logic [EXC_W-1:0] exc_adj;
  logic [EXC_W-1:0] enabled;
  logic [EXC_W-1:0] first;
  always_comb begin
    exc_adj = exc_in;
    // Overflow always comes with inexact; untrapped underflow does too.
    if (exc_in[EXC_OF] || (exc_in[EXC_UF] && !tem_in[EXC_UF])) begin
      exc_adj[EXC_NX] = 1'b1;
    end
    enabled = exc_adj & tem_in; // see RL21
    // Only one trapping bit may survive, so the higher index wins and inexact comes last.
    first = 5'h00;
    if (enabled[EXC_NV]) begin
      first = 5'h10;
    end else if (enabled[EXC_OF]) begin
      first = 5'h08;
    end else if (enabled[EXC_UF]) begin
      first = 5'h04;
    end else if (enabled[EXC_DZ]) begin
      first = 5'h02;
    end else if (enabled[EXC_NX]) begin
      first = 5'h01;
    end
    trap_out = |enabled; // see RL12
    // A trapping case keeps exactly one bit, else all detected bits. (see RL16) (see RL17)
    cexc_out = trap_out ? first : exc_adj; // see RL15
  end
endmodule : fes_cexc_res

// File: verilog/fes_core.sv
module fes_core #(
  parameter logic [2:0] VER_CODE = fes_pkg::VER_DEFAULT
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Operation report from the datapath
  input wire logic op_valid_in,
  input wire logic op_not_in_hw_in,
  input wire logic op_quad_in,
  input wire logic op_incomplete_in,
  input wire logic [2:0] op_quad_regs_in,
  input wire logic [5:0] op_rs1_in,
  input wire logic [5:0] op_rs2_in,
  input wire logic [5:0] op_rd_in,
  input wire logic [fes_pkg::EXC_W-1:0] exc_in,
  // Status register load and store
  input wire logic status_load_32_in,
  input wire logic status_load_64_in,
  input wire logic [fes_pkg::STAT_W-1:0] status_wdata_in,
  input wire logic status_store_in,
  input wire logic store_err_in,
  // Results
  output logic [fes_pkg::STAT_W-1:0] float_status_control_out,
  output logic float_ieee_trap_out,
  output logic float_misc_trap_out
);
  import fes_pkg::*;

  logic [EXC_W-1:0] cexc_r, cexc_nxt;
  logic [EXC_W-1:0] aexc_r, aexc_nxt;
  logic [EXC_W-1:0] tem_r, tem_nxt;
  logic [2:0] ftt_r, ftt_nxt;
  logic [1:0] rd_r, rd_nxt;
  logic [1:0] fcc0_r, fcc0_nxt;
  logic [5:0] fcchi_r, fcchi_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt;
  logic ieee_trap_r, ieee_trap_nxt;
  logic misc_trap_r, misc_trap_nxt;

  logic not_in_hw;
  logic misaligned;
  logic [EXC_W-1:0] res_cexc;
  logic res_trap;
  logic [2:0] enc_ftt;
  logic other_trap;

  // Quad operations are never in hardware. (see RL5)
  assign not_in_hw = op_not_in_hw_in | op_quad_in;
  assign misaligned = (op_quad_regs_in[0] && (op_rs1_in[1:0] != 2'h0)) ||
                      (op_quad_regs_in[1] && (op_rs2_in[1:0] != 2'h0)) ||
                      (op_quad_regs_in[2] && (op_rd_in[1:0] != 2'h0)); // see RL6

  fes_cexc_res u_res (
    .exc_in(exc_in),
    .tem_in(tem_r),
    .cexc_out(res_cexc),
    .trap_out(res_trap)
  );

  fes_ftt_enc u_enc (
    .not_in_hw_in(not_in_hw),
    .misaligned_in(misaligned),
    .incomplete_in(op_incomplete_in),
    .ieee_in(res_trap),
    .ftt_out(enc_ftt)
  );

  assign other_trap = (enc_ftt != FTT_NONE) && (enc_ftt != FTT_IEEE);

  // Operations and loads are separate instructions; if both arrive, the operation wins.
  always_comb begin
    cexc_nxt = cexc_r;
    aexc_nxt = aexc_r;
    tem_nxt = tem_r;
    ftt_nxt = ftt_r;
    rd_nxt = rd_r;
    fcc0_nxt = fcc0_r;
    fcchi_nxt = fcchi_r;
    ieee_trap_nxt = 1'b0;
    misc_trap_nxt = 1'b0;
    if (op_valid_in) begin
      ftt_nxt = enc_ftt; // see RL18
      if (other_trap) begin
        // Current and accrued fields stay as they are. (see RL3) (see RL4) (see RL8)
        misc_trap_nxt = 1'b1;
      end else if (res_trap) begin
        cexc_nxt = res_cexc; // see RL2
        ieee_trap_nxt = 1'b1; // see RL9
      end else begin
        cexc_nxt = res_cexc; // see RL14
        aexc_nxt = aexc_r | res_cexc; // see RL11
      end
    end else if (status_load_32_in || status_load_64_in) begin
      // Trap type, version and queue bit are not loadable. (see RL20) (see RL10)
      cexc_nxt = status_wdata_in[CEXC_LSB +: EXC_W];
      aexc_nxt = status_wdata_in[AEXC_LSB +: EXC_W]; // see RL13
      tem_nxt = status_wdata_in[TEM_LSB +: EXC_W];
      rd_nxt = status_wdata_in[RD_LSB +: 2];
      fcc0_nxt = status_wdata_in[FCC0_LSB +: 2];
      if (status_load_64_in) begin
        fcchi_nxt = status_wdata_in[FCCHI_LSB +: 6];
      end
    end else if (status_store_in && !store_err_in) begin
      ftt_nxt = FTT_NONE; // see RL20
    end
  end

  // The output image is registered so the status value never has a combinational path.
  always_comb begin
    stat_nxt = '0;
    stat_nxt[CEXC_LSB +: EXC_W] = cexc_nxt;
    stat_nxt[AEXC_LSB +: EXC_W] = aexc_nxt;
    stat_nxt[FCC0_LSB +: 2] = fcc0_nxt;
    stat_nxt[QNE_BIT] = 1'b0; // see RL10
    stat_nxt[FTT_LSB +: 3] = ftt_nxt;
    stat_nxt[VER_LSB +: 3] = VER_CODE;
    stat_nxt[TEM_LSB +: EXC_W] = tem_nxt;
    stat_nxt[RD_LSB +: 2] = rd_nxt;
    stat_nxt[FCCHI_LSB +: 6] = fcchi_nxt;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cexc_r <= EXC_RST;
      aexc_r <= EXC_RST;
      tem_r <= EXC_RST;
      ftt_r <= FTT_NONE;
      rd_r <= RD_RST;
      fcc0_r <= FCC0_RST;
      fcchi_r <= FCCHI_RST;
      stat_r <= '0;
      ieee_trap_r <= 1'b0;
      misc_trap_r <= 1'b0;
    end else begin
      cexc_r <= cexc_nxt;
      aexc_r <= aexc_nxt;
      tem_r <= tem_nxt;
      ftt_r <= ftt_nxt;
      rd_r <= rd_nxt;
      fcc0_r <= fcc0_nxt;
      fcchi_r <= fcchi_nxt;
      stat_r <= stat_nxt;
      ieee_trap_r <= ieee_trap_nxt;
      misc_trap_r <= misc_trap_nxt;
    end
  end

  assign float_status_control_out = stat_r;
  assign float_ieee_trap_out = ieee_trap_r;
  assign float_misc_trap_out = misc_trap_r;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_ftt_no_reserved: assert property (
    (stat_r[FTT_LSB +: 3] != 3'h4) && (stat_r[FTT_LSB +: 3] != 3'h5)) // see RL7
    else $error("Reserved trap type seen.");

  a_qne_reads_zero: assert property ( // see RL10
    status_load_64_in && status_wdata_in[QNE_BIT] |=> !float_status_control_out[QNE_BIT])
    else $error("Queue bit not zero.");

  a_not_in_hw_wins: assert property ( // see RL1
    op_valid_in && not_in_hw && misaligned |=>
      float_misc_trap_out && (float_status_control_out[FTT_LSB +: 3] == 3'h3))
    else $error("Unimplemented did not win.");

  a_misc_keeps_cexc: assert property ( // see RL4
    op_valid_in && other_trap |=> float_misc_trap_out &&
      $stable(float_status_control_out[CEXC_LSB +: EXC_W]) &&
      $stable(float_status_control_out[AEXC_LSB +: EXC_W]))
    else $error("Misc trap altered exception fields.");

  a_ieee_one_bit: assert property ( // see RL15
    float_ieee_trap_out |-> $onehot(float_status_control_out[CEXC_LSB +: EXC_W]) &&
      (float_status_control_out[FTT_LSB +: 3] == 3'h1) &&
      $stable(float_status_control_out[AEXC_LSB +: EXC_W]))
    else $error("IEEE trap result wrong.");

  a_accrue_or: assert property ( // see RL12
    op_valid_in && (enc_ftt == FTT_NONE) |=>
      (aexc_r == ($past(aexc_r) | cexc_r)) && !float_ieee_trap_out &&
      (float_status_control_out[FTT_LSB +: 3] == 3'h0))
    else $error("Accrued field not ORed.");

  a_of_both_masked: assert property ( // see RL16
    op_valid_in && !other_trap && (exc_in == 5'h08) && (tem_r == 5'h00) |=>
      (cexc_r == 5'h09) && !float_ieee_trap_out)
    else $error("Masked overflow result wrong.");

  a_uf_nx_enabled: assert property ( // see RL17
    op_valid_in && !other_trap && (exc_in == 5'h05) && (tem_r == 5'h01) |=>
      (cexc_r == 5'h01) && float_ieee_trap_out)
    else $error("Underflow with inexact trap wrong.");

  a_load_keeps_ftt: assert property ( // see RL20
    !op_valid_in && (status_load_32_in || status_load_64_in) |=>
      $stable(float_status_control_out[FTT_LSB +: 3]) &&
      (aexc_r == $past(status_wdata_in[AEXC_LSB +: EXC_W])))
    else $error("Load disturbed trap type.");

  a_store_clears: assert property ( // see RL20
    !op_valid_in && !status_load_32_in && !status_load_64_in && status_store_in &&
      !store_err_in |=> (float_status_control_out[FTT_LSB +: 3] == 3'h0))
    else $error("Store did not clear trap type.");

  c_ieee_trap: cover property (op_valid_in ##1 float_ieee_trap_out);
  c_misc_trap: cover property (op_valid_in && misaligned && !not_in_hw ##1 float_misc_trap_out);
  c_accrue: cover property (op_valid_in && (enc_ftt == FTT_NONE) && (exc_in != 5'h00));
  c_store_clear: cover property (float_ieee_trap_out ##[1:5] status_store_in && !store_err_in);
endmodule : fes_core

// File: verilog/fes_ftt_enc.sv
module fes_ftt_enc (
  // Detected conditions
  input wire logic not_in_hw_in,
  input wire logic misaligned_in,
  input wire logic incomplete_in,
  input wire logic ieee_in,
  // Encoded trap type
  output logic [2:0] ftt_out
);
  import fes_pkg::*;
  // Codes 4, 5 and 7 have no path here, so they cannot appear. (see RL7)
  always_comb begin
    if (not_in_hw_in) begin // see RL22
      ftt_out = FTT_NOT_IN_HW; // see RL1
    end else if (misaligned_in) begin
      ftt_out = FTT_MISALIGNED;
    end else if (incomplete_in) begin
      ftt_out = FTT_INCOMPLETE;
    end else if (ieee_in) begin
      ftt_out = FTT_IEEE;
    end else begin
      ftt_out = FTT_NONE; // see RL19
    end
  end
endmodule : fes_ftt_enc

// File: verilog/fes_pkg.sv
// Summary of operation
// RL1 - A missing operation reports unimplemented, never misaligned register, whatever registers are named.
// RL2 - IEEE trap records its exception in current field; accrued field stays untouched.
// RL3 - An incomplete operation raises the misc trap with type 2, current field unchanged.
// RL4 - An operation not in hardware raises the misc trap with type 3, current field kept.
// RL5 - Every quad-precision operation is treated as not implemented in hardware.
// RL6 - A quad operand register number not a multiple of four gives type 6.
// RL7 - Trap type values 4 and 5 are never produced.
// RL8 - Any floating trap leaves the accrued field and condition codes unchanged.
// RL9 - IEEE trap sets the trapping current bit; other traps keep the current field.
// RL10 - The queue-not-empty bit always reads zero and ignores writes.
// RL11 - Accrued field is bits 9:5 and gathers exceptions only while masked.
// RL12 - Without trap, mask AND current decides: trap keeps accrued, else OR into it.
// RL13 - Both status load widths write the accrued field with the supplied value.
// RL14 - Current field bits 4:0 show the last operation's exceptions, others cleared.
// RL15 - Only non-trapping or IEEE-trapping operations update current; trapping sets one bit.
// RL16 - Overflow: both masked set both no trap; else inexact or overflow alone, trap.
// RL17 - Underflow: both masked set both no trap; else inexact or underflow alone, trap.
// RL18 - Trap type field sits in bits 16:14 and names the trap cause.
// RL19 - Simultaneous conditions encode only the highest-priority one.
// RL20 - Trap type holds until a good store or non-trapping operation; loads keep it.
// RL21 - Trap enable mask is bits 27:23, one enable per current exception bit.
// RL22 - Priority is unimplemented, misaligned, incomplete, IEEE; zero when nothing detected.
package fes_pkg;
  localparam int STAT_W = 64;
  localparam int EXC_W = 5;
  // Field positions of the status register.
  localparam int CEXC_LSB = 0;
  localparam int AEXC_LSB = 5;
  localparam int FCC0_LSB = 10;
  localparam int QNE_BIT = 13;
  localparam int FTT_LSB = 14;
  localparam int VER_LSB = 17;
  localparam int TEM_LSB = 23;
  localparam int RD_LSB = 30;
  localparam int FCCHI_LSB = 32;
  // Bits inside each exception field.
  localparam int EXC_NV = 4;
  localparam int EXC_OF = 3;
  localparam int EXC_UF = 2;
  localparam int EXC_DZ = 1;
  localparam int EXC_NX = 0;
  // Trap type codes.
  localparam logic [2:0] FTT_NONE = 3'h0;
  localparam logic [2:0] FTT_IEEE = 3'h1;
  localparam logic [2:0] FTT_INCOMPLETE = 3'h2;
  localparam logic [2:0] FTT_NOT_IN_HW = 3'h3;
  localparam logic [2:0] FTT_MISALIGNED = 3'h6;
  // Reset values.
  localparam logic [4:0] EXC_RST = 5'h00;
  localparam logic [1:0] RD_RST = 2'h0;
  localparam logic [1:0] FCC0_RST = 2'h0;
  localparam logic [5:0] FCCHI_RST = 6'h00;
  // Version code is arbitrary.
  localparam logic [2:0] VER_DEFAULT = 3'h0;
endpackage : fes_pkg
